/* File: core/watchdog_pkg.sv */
// constants and types shared by the watchdog control block
package watchdog_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int           ADDR_W          = 4;
  localparam logic [3:0]   CTRL_OFFSET     = 4'h0;
  localparam logic [7:0]   CTRL_RESET      = 8'h00;

  // ---------------------------------------------------------------
  // field layout of watchdog_control
  // ---------------------------------------------------------------
  localparam int           UNLOCK_BIT      = 4;
  localparam int           RUN_BIT         = 3;
  localparam int           SEL_LSB         = 0;
  localparam int           SEL_W           = 3;
  localparam logic [2:0]   SEL_RESET       = 3'h0;
  localparam logic [2:0]   RSVD_VALUE      = 3'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  // change window length in system clock cycles
  localparam int           UNLOCK_CYCLES   = 4;
  localparam logic [1:0]   UNLOCK_LAST     = 2'(UNLOCK_CYCLES - 1);
  // shortest timeout in watchdog oscillator cycles (code 000)
  localparam int           BASE_TIMEOUT    = 16384;
  // counter width covering the longest timeout (code 111)
  localparam int           CNT_W           = 22;

  // ---------------------------------------------------------------
  // safety levels, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LEVEL0 = 3'b001,
    LEVEL1 = 3'b010,
    LEVEL2 = 3'b100
  } level_t;

endpackage

/* File: core/watchdog_timed_config.sv */
// watchdog control register, timed change sequence and timeout counter
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - control bits 7..5 always read zero; writes to them do nothing.
// - change-unlock bit written one together with run bit one clears itself after four clock cycles.
// - writing run bit one starts watchdog; accepted zero write stops it.
// - zero written to run bit is ignored unless unlock bit is set.
// - at level 2 no sequence can stop the watchdog.
// - timeout is 16K oscillator cycles at code 0, doubling up to 2048K.
// - level 0 starts stopped, enables freely, timeout changes anytime.
// - level 1 starts stopped, enables freely, timed sequence for changes.
// - level 2 watchdog always runs; run bit reads back one.
// - level 2 timeout change uses timed sequence; run value ignored.
// - two fuses pick the level; always-on fuse means level 2, running.
// - kick, disable and chip reset clear the timeout counter.
// - expiry without kick gives a one-cycle reset pulse.
module watchdog_timed_config #(
  parameter int BASE_CYCLES = watchdog_pkg::BASE_TIMEOUT
) (
  // clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            sys_rst,
  // register port
  input  wire logic [watchdog_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [7:0]                      regWdata,
  input  wire logic                            regWr,
  input  wire logic                            regRd,
  output logic      [7:0]                      regRdataQ,
  // fuses, high means programmed
  input  wire logic                            alwaysOnFuse,
  input  wire logic                            legacyCompatFuse,
  // watchdog oscillator and kick instruction
  input  wire logic                            dogOsc,
  input  wire logic                            kickInstruction,
  // status and reset request
  output logic                                 dogRunQ,
  output logic                                 dogResetQ
);

  // ---------------------------------------------------------------
  // safety level decode
  // ---------------------------------------------------------------
  watchdog_pkg::level_t level;

  // fuses are static, so a plain decode is enough
  always_comb begin
    if (alwaysOnFuse) begin
      level = watchdog_pkg::LEVEL2;
    end else if (legacyCompatFuse) begin
      level = watchdog_pkg::LEVEL0;
    end else begin
      level = watchdog_pkg::LEVEL1;
    end
  end

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  logic                           ctrlWr;
  logic                           wrUnlock;
  logic                           wrRun;
  logic [watchdog_pkg::SEL_W-1:0] wrSel;
  logic                           openWr;
  logic                           closeWr;
  logic                           unlockQ;
  logic [1:0]                     unlockCntQ;
  logic [watchdog_pkg::SEL_W-1:0] selQ;

  // upper bits of the write are never looked at
  assign ctrlWr   = regWr && (regAddr == watchdog_pkg::CTRL_OFFSET);
  assign wrUnlock = regWdata[watchdog_pkg::UNLOCK_BIT];
  assign wrRun    = regWdata[watchdog_pkg::RUN_BIT];
  assign wrSel    = regWdata[watchdog_pkg::SEL_LSB +: watchdog_pkg::SEL_W];
  // opening needs both bits, so unlock alone cannot arm the window
  assign openWr   = ctrlWr && wrUnlock && wrRun;
  // completion only counts while the window is open
  assign closeWr  = ctrlWr && !wrUnlock && unlockQ;

  // ---------------------------------------------------------------
  // change window
  // ---------------------------------------------------------------
  // a fresh opening restarts the four-cycle window
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      unlockQ    <= 1'b0;
      unlockCntQ <= 2'h0;
    end else if (openWr) begin
      unlockQ    <= 1'b1;
      unlockCntQ <= 2'h0;
    end else if (closeWr) begin
      unlockQ    <= 1'b0;
      unlockCntQ <= 2'h0;
    end else if (unlockQ) begin
      if (unlockCntQ == watchdog_pkg::UNLOCK_LAST) begin
        unlockQ    <= 1'b0;
        unlockCntQ <= 2'h0;
      end else begin
        unlockCntQ <= unlockCntQ + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // run bit
  // ---------------------------------------------------------------
  // chip reset reloads the start state from the always-on fuse
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dogRunQ <= alwaysOnFuse;
    end else begin
      case (level)
        watchdog_pkg::LEVEL2: begin
          dogRunQ <= 1'b1;
        end
        watchdog_pkg::LEVEL0, watchdog_pkg::LEVEL1: begin
          if (ctrlWr && wrRun) begin
            dogRunQ <= 1'b1;
          end else if (closeWr) begin
            dogRunQ <= wrRun;
          end
        end
        default: begin
          dogRunQ <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // timeout select
  // ---------------------------------------------------------------
  // at levels 1 and 2 only a completing write may move the select
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      selQ <= watchdog_pkg::SEL_RESET;
    end else begin
      case (level)
        watchdog_pkg::LEVEL0: begin
          if (ctrlWr) begin
            selQ <= wrSel;
          end
        end
        watchdog_pkg::LEVEL1, watchdog_pkg::LEVEL2: begin
          if (closeWr) begin
            selQ <= wrSel;
          end
        end
        default: begin
          selQ <= selQ;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [7:0] ctrlView;

  assign ctrlView = {watchdog_pkg::RSVD_VALUE, unlockQ, dogRunQ, selQ};

  // data stand one cycle only; unmapped or idle reads give zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdataQ <= watchdog_pkg::CTRL_RESET;
    end else if (regRd && (regAddr == watchdog_pkg::CTRL_OFFSET)) begin
      regRdataQ <= ctrlView;
    end else begin
      regRdataQ <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // oscillator synchroniser
  // ---------------------------------------------------------------
  logic oscMetaQ;
  logic oscSyncQ;
  logic oscPrevQ;
  logic oscTick;

  // first stage feeds only the second; edges found after that
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      oscMetaQ <= 1'b0;
      oscSyncQ <= 1'b0;
      oscPrevQ <= 1'b0;
    end else begin
      oscMetaQ <= dogOsc;
      oscSyncQ <= oscMetaQ;
      oscPrevQ <= oscSyncQ;
    end
  end

  assign oscTick = oscSyncQ && !oscPrevQ;

  // ---------------------------------------------------------------
  // timeout counter
  // ---------------------------------------------------------------
  logic [watchdog_pkg::CNT_W-1:0] cntQ;
  logic [watchdog_pkg::CNT_W-1:0] limit;
  logic                           expire;

  // the oscillator must run well below half of sys_clk to be seen
  assign limit  = watchdog_pkg::CNT_W'(BASE_CYCLES) << selQ;
  // a select shortened below the running count fires on the next tick instead of waiting for a wrap
  assign expire = dogRunQ && oscTick && (cntQ >= limit - 1'b1);

  // kick has priority over a tick landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !dogRunQ || kickInstruction) begin
      cntQ <= '0;
    end else if (expire) begin
      cntQ <= '0;
    end else if (oscTick) begin
      cntQ <= cntQ + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // reset request
  // ---------------------------------------------------------------
  // one cycle pulse; the reset generator outside restarts the core
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dogResetQ <= 1'b0;
    end else begin
      dogResetQ <= expire && !kickInstruction;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_reserved_read_zero: assert property (
    regRd |=> (regRdataQ[7:5] == 3'h0)
  ) else $error("reserved control bits read nonzero");

  a_unlock_self_clear: assert property (
    openWr ##1 (!openWr)[*4] |=> !unlockQ
  ) else $error("unlock bit outlived its four cycle window");

  a_unlock_held_open: assert property (
    openWr ##1 (!ctrlWr)[*3] |-> unlockQ
  ) else $error("unlock bit dropped before four cycles");

  a_run_start_write: assert property (
    (ctrlWr && wrRun) |=> dogRunQ
  ) else $error("writing run bit one did not start the watchdog");

  a_stop_needs_unlock: assert property (
    (ctrlWr && !wrRun && !unlockQ && dogRunQ) |=> dogRunQ
  ) else $error("watchdog stopped without unlock");

  a_timed_stop: assert property (
    (closeWr && !wrRun && !alwaysOnFuse) |=> !dogRunQ ##1 (cntQ == '0)
  ) else $error("timed disable did not stop and clear");

  a_level2_always_run: assert property (
    alwaysOnFuse |-> dogRunQ && (ctrlView[watchdog_pkg::RUN_BIT] == 1'b1)
  ) else $error("watchdog not running at level two");

  a_expire_at_limit: assert property (
    dogResetQ |-> $past(cntQ) >= $past(limit) - 1'b1
  ) else $error("reset pulse not at selected timeout");

  a_level0_free_sel: assert property (
    (level == watchdog_pkg::LEVEL0 && ctrlWr) |=> (selQ == $past(wrSel))
  ) else $error("level zero select write not taken");

  a_locked_sel_hold: assert property (
    (level != watchdog_pkg::LEVEL0 && ctrlWr && !closeWr) |=> $stable(selQ)
  ) else $error("select changed outside the timed sequence");

  a_kick_clears_cnt: assert property (
    kickInstruction |=> (cntQ == '0)
  ) else $error("kick did not clear the counter");

  a_reset_pulse_one: assert property (
    dogResetQ |=> !dogResetQ
  ) else $error("reset pulse longer than one cycle");

  // window, completion and counter details
  a_open_needs_run: assert property (
    (ctrlWr && wrUnlock && !wrRun && !unlockQ) |=> !unlockQ
  ) else $error("unlock write without run bit opened the window");

  a_unlock_only_open: assert property (
    (!unlockQ && !openWr) |=> !unlockQ
  ) else $error("window opened without an opening write");

  a_level1_complete: assert property (
    (level == watchdog_pkg::LEVEL1 && closeWr) |=> (dogRunQ == $past(wrRun)) && (selQ == $past(wrSel)) && !unlockQ
  ) else $error("level one completing write not applied");

  a_level2_sel_change: assert property (
    (alwaysOnFuse && closeWr) |=> (selQ == $past(wrSel)) && dogRunQ
  ) else $error("level two completing write not applied");

  a_stopped_cnt_zero: assert property (
    !dogRunQ |=> (cntQ == '0)
  ) else $error("counter not cleared while stopped");

  a_kick_no_pulse: assert property (
    kickInstruction |=> !dogResetQ
  ) else $error("reset pulse despite kick");

  a_tick_advances: assert property (
    (dogRunQ && oscTick && !kickInstruction && !expire) |=> (cntQ == $past(cntQ) + 1'b1)
  ) else $error("oscillator tick not counted");

  // ---------------------------------------------------------------
  // coverage of main scenarios
  // ---------------------------------------------------------------
  c_timed_disable: cover property (
    openWr ##[1:4] (closeWr && !wrRun)
  );

  c_window_lapse: cover property (
    openWr ##1 (!ctrlWr)[*4] ##1 ctrlWr
  );

  c_level2_sel_change: cover property (
    alwaysOnFuse && openWr ##[1:4] closeWr
  );

  c_timeout_reset: cover property (
    dogResetQ
  );

  c_level1_sel_change: cover property (
    (level == watchdog_pkg::LEVEL1 && openWr) ##[1:4] closeWr
  );

endmodule

`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the watchdog control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int BASE = 4;
  logic       sys_clk, sys_rst, regWr, regRd, alwaysOnFuse, legacyCompatFuse, dogOsc, kickInstruction;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdataQ, rd;
  logic       dogRunQ, dogResetQ;
  int         mismatches, check_count, pulses, p0;

  watchdog_timed_config #(.BASE_CYCLES(BASE)) u_watchdog_timed_config (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdataQ(regRdataQ), .alwaysOnFuse(alwaysOnFuse), .legacyCompatFuse(legacyCompatFuse),
    .dogOsc(dogOsc), .kickInstruction(kickInstruction), .dogRunQ(dogRunQ), .dogResetQ(dogResetQ));

  // ----------------------------------------------------------------
  // clock, pulse monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // every high cycle counts, so a stretched pulse shows up as extra
  always @(posedge sys_clk) begin
    if (dogResetQ === 1'b1) pulses++;
  end
  initial begin
    #3000000;
    mismatches++;
    final_report();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // fuses are static, so each level gets its own reset
  task automatic do_reset(input logic aon, input logic legacy);
    alwaysOnFuse <= aon;
    legacyCompatFuse <= legacy;
    sys_rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
  endtask
  // leading edge wait keeps strobes from being re-driven in one step
  // trailing edge lets callers look at outputs already settled by the write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input string name, input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 check(name, regRdataQ, exp);
    @(posedge sys_clk);
    #1 check("rdata idle", regRdataQ, 8'h00);
  endtask
  // oscillator phases of 2 cycles each; optional kick every kEvery ticks
  task automatic ticks(input int n, input int kEvery);
    for (int i = 0; i < n; i++) begin
      dogOsc <= 1'b1;
      repeat (2) @(posedge sys_clk);
      dogOsc <= 1'b0;
      repeat (2) @(posedge sys_clk);
      if (kEvery > 0 && i % kEvery == 0) begin
        kickInstruction <= 1'b1;
        @(posedge sys_clk);
        kickInstruction <= 1'b0;
      end
    end
    repeat (10) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    {sys_rst, regWr, regRd, alwaysOnFuse, legacyCompatFuse, dogOsc, kickInstruction} = 7'h01 << 6;
    regAddr = 4'h0;
    regWdata = 8'h00;
    mismatches = 0;
    check_count = 0;
    pulses = 0;
    // level 1: free enable, guarded disable and select change
    do_reset(1'b0, 1'b0);
    rdchk("reset value", 4'h0, 8'h00);
    wr(4'h0, 8'hE9);
    rdchk("reserved and sel", 4'h0, 8'h08);
    wr(4'h0, 8'h00);
    rdchk("zero run ignored", 4'h0, 8'h08);
    wr(4'h0, 8'h18);
    repeat (6) @(posedge sys_clk);
    rdchk("unlock self clear", 4'h0, 8'h08);
    wr(4'h0, 8'h02);
    rdchk("late change", 4'h0, 8'h08);
    wr(4'h0, 8'h18);
    rdchk("window open", 4'h0, 8'h18);
    // unlock without run is no opening, so the completion is refused
    wr(4'h0, 8'h10);
    wr(4'h0, 8'h03);
    rdchk("open needs run", 4'h0, 8'h08);
    // the read above outlasts the window, so open again right before completing
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h02);
    rdchk("completing", 4'h0, 8'h02);
    check("run after stop", {7'h00, dogRunQ}, 8'h00);
    $display("test level1 done");
    // level 0: free select, unmapped address, every timeout code
    do_reset(1'b0, 1'b1);
    wr(4'h1, 8'h0D);
    rdchk("unmapped read", 4'h1, 8'h00);
    check("unmapped write", {7'h00, dogRunQ}, 8'h00);
    wr(4'h0, 8'h05);
    rdchk("free select", 4'h0, 8'h05);
    for (int s = 0; s < 8; s++) begin
      wr(4'h0, 8'h08 | 8'(s));
      check("run started", {7'h00, dogRunQ}, 8'h01);
      p0 = pulses;
      ticks(2 * (BASE << s) + (BASE << s) / 2, 0);
      check("pulses per code", 8'(pulses - p0), 8'h02);
      wr(4'h0, 8'h18);
      wr(4'h0, 8'(s));
      check("run stopped", {7'h00, dogRunQ}, 8'h00);
    end
    $display("test level0 done");
    // level 2: always running, select change only by sequence
    do_reset(1'b1, 1'b0);
    check("run at start", {7'h00, dogRunQ}, 8'h01);
    rdchk("run reads one", 4'h0, 8'h08);
    wr(4'h0, 8'h03);
    rdchk("unguarded select", 4'h0, 8'h08);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h00);
    check("no disable", {7'h00, dogRunQ}, 8'h01);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h02);
    rdchk("guarded select", 4'h0, 8'h0A);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h00);
    p0 = pulses;
    ticks(12, 2);
    check("kicked no pulse", 8'(pulses - p0), 8'h00);
    p0 = pulses;
    ticks(2 * BASE + 2, 0);
    check("expiry pulses", 8'(pulses - p0), 8'h02);
    $display("test level2 done");
    final_report();
  end
endmodule
`default_nettype wire
